// File: src/spims_port.sv
// Serial master/slave port: register file, shifter, flags and pin control.
// Assumes pins are synchronous to clk and strobes are single cycle, never both.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "spims_defs.svh"
module spims_port import spims_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire spims_bus_req_type busReq,
  output logic [`SPIMS_DATA_W-1:0] rdata,
  // Serial pins
  input wire logic sckIn,
  input wire logic mosiIn,
  input wire logic misoIn,
  input wire logic ssN,
  output var spims_pins_type pinOut,
  // Interrupt requests
  output logic txIrq,
  output logic rxErrIrq
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] ctrlBase;
  logic [7:0] shReg_q;
  logic [7:0] shReg_d;
  logic [7:0] shSample;
  logic [7:0] rxNew;
  logic [7:0] rxBuf_q;
  logic [7:0] rxBuf_d;
  logic [7:0] txHold_q;
  logic [7:0] txHold_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] statusByte;
  logic [2:0] bitCnt_q;
  logic [2:0] bitCnt_d;
  logic [3:0] edgeCnt_q;
  logic [3:0] edgeCnt_d;
  logic [2:0] rateSel;
  spims_state_type state_q;
  spims_state_type state_d;
  logic dnFlag_q;
  logic dnFlag_d;
  logic colFlag_q;
  logic colFlag_d;
  logic mfFlag_q;
  logic mfFlag_d;
  logic selErr_q;
  logic selErr_d;
  logic dnArm_q;
  logic dnArm_d;
  logic colArm_q;
  logic colArm_d;
  logic mfArm_q;
  logic mfArm_d;
  logic resend_q;
  logic resend_d;
  logic sck_q;
  logic sck_d;
  logic outBit_q;
  logic outBit_d;
  logic portEn;
  logic selDis;
  logic masterSel;
  logic clock_polarity;
  logic clock_phase;
  logic isMaster;
  logic isSlave;
  logic selected;
  logic hitCtrl;
  logic hitStat;
  logic hitData;
  logic wrCtrl;
  logic wrData;
  logic rdCtrl;
  logic rdStat;
  logic rdData;
  logic accStat;
  logic accData;
  logic tick;
  logic rateOk;
  logic sckRise;
  logic sckFall;
  logic ssRise;
  logic mBusy;
  logic busy;
  logic mLead;
  logic mTrail;
  logic sLead;
  logic sTrail;
  logic sampleEdge;
  logic driveEdge;
  logic inBit;
  logic fault;
  logic loadOk;
  logic mStart;
  logic mDone;
  logic sDone;
  logic done;
  logic dnClr;
  logic colClr;
  logic ssErrEv;

  // Control fields
  assign portEn = ctrl_q[`SPIMS_CB_ENABLE];
  assign selDis = ctrl_q[`SPIMS_CB_SELDIS];
  assign masterSel = ctrl_q[`SPIMS_CB_MASTER];
  assign clock_polarity = ctrl_q[`SPIMS_CB_CLOCK_POLARITY];
  assign clock_phase = ctrl_q[`SPIMS_CB_CLOCK_PHASE];
  assign rateSel = {ctrl_q[`SPIMS_CB_RATE2], ctrl_q[`SPIMS_CB_RATE1], ctrl_q[`SPIMS_CB_RATE0]};
  assign isMaster = portEn & masterSel;
  assign isSlave = portEn & ~masterSel;
  // Select is ignored only in phase 1 with select disabled
  assign selected = ~ssN | (selDis & clock_phase);

  // Address decode
  assign hitCtrl = busReq.addr == `SPIMS_ADDR_CTRL;
  assign hitStat = busReq.addr == `SPIMS_ADDR_STAT;
  assign hitData = busReq.addr == `SPIMS_ADDR_DATA;
  assign wrCtrl = busReq.wr & hitCtrl;
  assign wrData = busReq.wr & hitData;
  assign rdCtrl = busReq.rd & hitCtrl;
  assign rdStat = busReq.rd & hitStat;
  assign rdData = busReq.rd & hitData;
  assign accStat = (busReq.wr | busReq.rd) & hitStat;
  assign accData = (busReq.wr | busReq.rd) & hitData;

  spims_rate_gen #(
    .RATE_W(`SPIMS_RATE_W),
    .CNT_W(`SPIMS_DIV_W)
  ) u_rate (
    .clk(clk),
    .rstn(rstn),
    .clear(~mBusy),
    .rateSel(rateSel),
    .tick(tick),
    .rateOk(rateOk)
  );

  spims_edge_det #(
    .INIT(1'b0)
  ) u_sck_edge (
    .clk(clk),
    .rstn(rstn),
    .level(sckIn),
    .rise(sckRise),
    .fall(sckFall)
  );

  spims_edge_det #(
    .INIT(1'b1)
  ) u_ss_edge (
    .clk(clk),
    .rstn(rstn),
    .level(ssN),
    .rise(ssRise),
    .fall()
  );

  // Edge classification: leading leaves the idle level
  assign mBusy = isMaster & (state_q == SPIMS_XFER);
  assign busy = isMaster ? mBusy : (bitCnt_q != 3'h0);
  assign mLead = mBusy & tick & (sck_q == clock_polarity);
  assign mTrail = mBusy & tick & (sck_q != clock_polarity);
  assign sLead = isSlave & selected & (clock_polarity ? sckFall : sckRise);
  assign sTrail = isSlave & selected & (clock_polarity ? sckRise : sckFall);
  assign sampleEdge = clock_phase ? (mTrail | sTrail) : (mLead | sLead);
  assign driveEdge = clock_phase ? (mLead | sLead) : (mTrail | sTrail);
  assign inBit = masterSel ? misoIn : mosiIn;
  assign shSample = {shReg_q[6:0], inBit};
  assign rxNew = sampleEdge ? shSample : shReg_q;

  // Master sequencing
  assign fault = isMaster & ~selDis & ~ssN;
  assign loadOk = wrData & ~busy;
  assign mStart = isMaster & (state_q == SPIMS_IDLE) & rateOk & (loadOk | resend_q);
  assign mDone = mBusy & tick & (edgeCnt_q == `SPIMS_LAST_EDGE) & ~fault;
  assign sDone = isSlave & sampleEdge & (bitCnt_q == `SPIMS_LAST_BIT);
  assign done = mDone | sDone;

  assign state_d = (!isMaster || fault) ? SPIMS_IDLE :
                   mStart ? SPIMS_XFER :
                   mDone ? SPIMS_IDLE : state_q;
  assign edgeCnt_d = (!mBusy || mStart) ? 4'h0 : tick ? 4'(edgeCnt_q + 1'b1) : edgeCnt_q;
  // Sixteen toggles bring the clock back to its idle level
  assign sck_d = (!mBusy || fault) ? clock_polarity : tick ? ~sck_q : sck_q;
  assign bitCnt_d = (!portEn || fault || mStart || (isSlave && !selected)) ? 3'h0 :
                    sampleEdge ? 3'(bitCnt_q + 1'b1) : bitCnt_q;

  // Aborted byte is reloaded so a restart resends it
  assign shReg_d = (fault && mBusy) ? txHold_q :
                   loadOk ? busReq.wdata :
                   sampleEdge ? shSample : shReg_q;
  assign txHold_d = loadOk ? busReq.wdata : txHold_q;
  assign resend_d = (fault && mBusy) ? 1'b1 : (mStart || loadOk) ? 1'b0 : resend_q;
  // Idle output follows the MSB so phase 0 data is ready before the first edge
  assign outBit_d = loadOk ? busReq.wdata[`SPIMS_MSB] :
                    (!busy || driveEdge) ? shReg_q[`SPIMS_MSB] : outBit_q;

  // Flags: a set in the same cycle as a clear wins
  assign dnClr = rdData & dnArm_q;
  assign dnFlag_d = done | (dnFlag_q & ~dnClr);
  assign dnArm_d = (rdStat & dnFlag_q) | (dnArm_q & ~rdData);
  assign rxBuf_d = (done && (!dnFlag_q || dnClr)) ? rxNew : rxBuf_q;
  assign colClr = accData & colArm_q;
  assign colFlag_d = (wrData & busy) | (colFlag_q & ~colClr);
  assign colArm_d = accStat | (colArm_q & ~accData);
  assign mfFlag_d = fault | (mfFlag_q & ~(wrCtrl & mfArm_q));
  assign mfArm_d = (rdStat & mfFlag_q) | (mfArm_q & ~wrCtrl);
  assign ssErrEv = isSlave & ssRise & ~(selDis & clock_phase) & (bitCnt_q != 3'h0);
  assign selErr_d = portEn & (ssErrEv | selErr_q);

  // Fault wins over a control write in the same cycle
  assign ctrlBase = wrCtrl ? busReq.wdata : ctrl_q;
  assign ctrl_d = fault ? (ctrlBase & ~`SPIMS_FAULT_MASK) : ctrlBase;

  always_comb begin
    statusByte = 8'h00;
    statusByte[`SPIMS_SB_DONE] = dnFlag_q;
    statusByte[`SPIMS_SB_COL] = colFlag_q;
    statusByte[`SPIMS_SB_SELERR] = selErr_q;
    statusByte[`SPIMS_SB_FAULT] = mfFlag_q;
  end

  // Data reads return the receive buffer, never the shifter
  assign rdata_d = rdStat ? statusByte :
                   rdData ? rxBuf_q :
                   rdCtrl ? ctrl_q : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `SPIMS_CTRL_RESET;
      rdata_q <= 8'h00;
      state_q <= SPIMS_IDLE;
      edgeCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
      sck_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      edgeCnt_q <= edgeCnt_d;
      bitCnt_q <= bitCnt_d;
      sck_q <= sck_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shReg_q <= 8'h00;
      txHold_q <= 8'h00;
      rxBuf_q <= 8'h00;
      outBit_q <= 1'b0;
      resend_q <= 1'b0;
    end else begin
      shReg_q <= shReg_d;
      txHold_q <= txHold_d;
      rxBuf_q <= rxBuf_d;
      outBit_q <= outBit_d;
      resend_q <= resend_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dnFlag_q <= 1'b0;
      colFlag_q <= 1'b0;
      mfFlag_q <= 1'b0;
      selErr_q <= 1'b0;
      dnArm_q <= 1'b0;
      colArm_q <= 1'b0;
      mfArm_q <= 1'b0;
    end else begin
      dnFlag_q <= dnFlag_d;
      colFlag_q <= colFlag_d;
      mfFlag_q <= mfFlag_d;
      selErr_q <= selErr_d;
      dnArm_q <= dnArm_d;
      colArm_q <= colArm_d;
      mfArm_q <= mfArm_d;
    end
  end

  // Pins: the master drives clock and data out, a selected slave drives its output
  assign pinOut.sck = sck_q;
  assign pinOut.sckOe = isMaster;
  assign pinOut.mosi = outBit_q;
  assign pinOut.mosiOe = isMaster;
  assign pinOut.miso = outBit_q;
  assign pinOut.misoOe = isSlave & selected;
  assign rdata = rdata_q;
  assign txIrq = dnFlag_q;
  assign rxErrIrq = mfFlag_q & ~selDis;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_stat_done;
    rdStat && dnFlag_q;
  endsequence

  sequence s_data_rd;
    rdData && !done;
  endsequence

  sequence s_stat_fault;
    rdStat && mfFlag_q;
  endsequence

  a_master_start: assert property (
    (isMaster && state_q == SPIMS_IDLE && wrData && rateOk && !fault) |=> mBusy)
    else $error("master write did not start a transfer");

  a_done_flag: assert property (
    done |=> dnFlag_q)
    else $error("done flag not set after a byte");

  a_rx_copy: assert property (
    (done && !dnFlag_q) |=> (rxBuf_q == $past(rxNew)))
    else $error("received byte not copied to buffer");

  a_transfer_done_flag_clear: assert property (
    s_stat_done ##1 s_data_rd |=> !dnFlag_q)
    else $error("done flag not cleared by read sequence");

  a_fault_stop: assert property (
    fault |=> (mfFlag_q && !portEn && !masterSel && state_q == SPIMS_IDLE && rxErrIrq == !selDis))
    else $error("mode fault did not shut the port down");

  a_mode_fault_flag_clear: assert property (
    s_stat_fault ##1 (wrCtrl && !fault) |=> !mfFlag_q)
    else $error("mode fault not cleared by control write");

  a_write_collision_flag_keep: assert property (
    (wrData && mBusy && !fault && !mDone) |=> (colFlag_q && mBusy))
    else $error("collision not flagged or transfer lost");

  a_rate_fast: assert property (
    (mBusy && tick && !fault && !mDone && rateSel == `SPIMS_RATE_MIN && !wrCtrl)
      |=> !tick ##1 (tick || !mBusy))
    else $error("fastest rate does not tick every two cycles");

  a_select_error_flag_clr: assert property (
    !portEn |=> !selErr_q)
    else $error("select error survived disable");

  a_miso_float: assert property (
    (ssN && !(selDis && clock_phase)) |-> !pinOut.misoOe)
    else $error("slave output driven while deselected");

  a_sck_idle: assert property (
    (isMaster && !mBusy && $past(!mBusy) && $stable(clock_polarity)) |-> (pinOut.sck == clock_polarity))
    else $error("serial clock not at idle level");
endmodule
`default_nettype wire

// File: src/spims_defs.svh
// Constants for the serial master/slave port: offsets, field positions, counts.
// Assumes inclusion by bare name from the package and the port module.
`ifndef SPIMS_DEFS_SVH
`define SPIMS_DEFS_SVH
`define SPIMS_ADDR_W 8
`define SPIMS_DATA_W 8
`define SPIMS_ADDR_CTRL 8'hC3
`define SPIMS_ADDR_STAT 8'hC4
`define SPIMS_ADDR_DATA 8'hC5
`define SPIMS_CTRL_RESET 8'h14
`define SPIMS_CB_RATE2 7
`define SPIMS_CB_ENABLE 6
`define SPIMS_CB_SELDIS 5
`define SPIMS_CB_MASTER 4
`define SPIMS_CB_CLOCK_POLARITY 3
`define SPIMS_CB_CLOCK_PHASE 2
`define SPIMS_CB_RATE1 1
`define SPIMS_CB_RATE0 0
`define SPIMS_FAULT_MASK 8'h50
`define SPIMS_SB_DONE 7
`define SPIMS_SB_COL 6
`define SPIMS_SB_SELERR 5
`define SPIMS_SB_FAULT 4
`define SPIMS_MSB 7
`define SPIMS_RATE_W 3
`define SPIMS_RATE_MIN 3'h1
`define SPIMS_RATE_MAX 3'h6
`define SPIMS_DIV_W 7
`define SPIMS_LAST_BIT 3'h7
`define SPIMS_LAST_EDGE 4'hF
`endif

// File: src/spims_pkg.sv
// Types shared by the serial port modules.
// Assumes the constants header sits beside this file.
`include "spims_defs.svh"
package spims_pkg;
  typedef struct packed {
    logic [`SPIMS_ADDR_W-1:0] addr;
    logic [`SPIMS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } spims_bus_req_type;

  typedef struct packed {
    logic sck;
    logic sckOe;
    logic mosi;
    logic mosiOe;
    logic miso;
    logic misoOe;
  } spims_pins_type;

  typedef enum logic {
    SPIMS_IDLE = 1'b0,
    SPIMS_XFER = 1'b1
  } spims_state_type;
endpackage

// File: src/spims_edge_det.sv
// Edge detector on a synchronous level.
// Assumes the level is already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module spims_edge_det import spims_pkg::*; #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level and edges
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= INIT;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule
`default_nettype wire

// File: src/spims_rate_gen.sv
// Half-period tick generator for the master serial clock.
// Assumes clear is held while no master transfer runs.
`timescale 1ns/1ns
`default_nettype none
`include "spims_defs.svh"
module spims_rate_gen import spims_pkg::*; #(
  parameter int RATE_W = `SPIMS_RATE_W,
  parameter int CNT_W = `SPIMS_DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic [RATE_W-1:0] rateSel,
  // Ticks
  output logic tick,
  output logic rateOk
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] halfLast;

  // Reserved codes give no clock at all
  assign rateOk = (rateSel >= `SPIMS_RATE_MIN) && (rateSel <= `SPIMS_RATE_MAX);
  // Half period is 2^code cycles, so the full period is 2^(code+1)
  assign halfLast = CNT_W'((CNT_W'(1) << rateSel) - CNT_W'(1));
  assign tick = rateOk && !clear && (cnt_q == halfLast);
  assign cnt_d = (clear || tick) ? '0 : CNT_W'(cnt_q + 1'b1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// File: testbench/spims_far_model.sv
// Far-side slave that answers the port's master transfers, polarity 0, phase 0.
// Assumes sck comes from a register synchronous to clk and selN from the bench.
`timescale 1ns/1ns
`default_nettype none
module spims_far_model (
  // Clock
  input wire logic clk,
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  output logic miso,
  // Byte data
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  logic sckQ = 1'b0;
  logic tog = 1'b0;
  logic [7:0] sh = 8'h00;
  // Deselected line keeps toggling so a stale bit never passes as data
  assign miso = selN ? tog : sh[7];
  always @(posedge clk) begin
    sckQ <= sck;
    tog <= ~tog;
    if (selN) begin
      sh <= txByte;
    end else if (sck && !sckQ) begin
      rxByte <= {rxByte[6:0], mosi};
    end else if (!sck && sckQ) begin
      sh <= {sh[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the serial port: registers, master, faults, slave.
// Assumes the port answers reads one cycle later and the far slave model.
`timescale 1ns/1ns
`default_nettype none
`include "spims_defs.svh"
module tb_top import spims_pkg::*;;
  localparam logic [7:0] CTRL = `SPIMS_ADDR_CTRL;
  localparam logic [7:0] STAT = `SPIMS_ADDR_STAT;
  localparam logic [7:0] DATA = `SPIMS_ADDR_DATA;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  spims_bus_req_type busReq = '0;
  logic [7:0] rdata;
  logic sckIn = 1'b0;
  logic mosiIn = 1'b0;
  logic ssN = 1'b1;
  logic pSel = 1'b1;
  logic [7:0] pTx = 8'h00;
  logic [7:0] pRx;
  logic misoLine;
  spims_pins_type pinOut;
  logic txIrq;
  logic rxErrIrq;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] d;

  always #4 clk = ~clk;

  spims_port dut (.clk(clk), .rstn(rstn), .busReq(busReq), .rdata(rdata),
    .sckIn(sckIn), .mosiIn(mosiIn), .misoIn(misoLine), .ssN(ssN),
    .pinOut(pinOut), .txIrq(txIrq), .rxErrIrq(rxErrIrq));
  spims_far_model far (.clk(clk), .sck(pinOut.sck), .mosi(pinOut.mosi),
    .selN(pSel), .miso(misoLine), .txByte(pTx), .rxByte(pRx));

  task automatic summarize();
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    // Read data stand only in this cycle; take them once settled
    @(negedge clk);
    v = rdata;
  endtask

  // Master byte at rate code c; waits the documented length plus margin
  task automatic mxfer(input logic [2:0] c, input logic [7:0] t, input logic [7:0] r,
                       input bit col);
    @(posedge clk);
    // The far model loads its byte only while deselected
    pTx <= r;
    @(posedge clk);
    pSel <= 1'b0;
    wreg(CTRL, {c[2], 3'b101, 2'b00, c[1:0]});
    wreg(DATA, t);
    if (col) begin
      wreg(DATA, 8'h00);
    end
    repeat ((16 << c) + 20) @(posedge clk);
    chk("far rx", t, pRx);
    chk("tx irq", 8'h01, {7'h00, txIrq});
    @(posedge clk);
    pSel <= 1'b1;
  endtask

  // Bench acts as external master, phase 0: n bits, sampling the port's miso
  task automatic sbits(input logic [7:0] b, input int n, output logic [7:0] g);
    ssN <= 1'b0;
    repeat (4) @(posedge clk);
    chk("miso oe", 8'h01, {7'h00, pinOut.misoOe});
    for (int i = 7; i > 7 - n; i--) begin
      mosiIn <= b[i];
      repeat (2) @(posedge clk);
      g[i] = pinOut.miso;
      sckIn <= 1'b1;
      repeat (4) @(posedge clk);
      sckIn <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    ssN <= 1'b1;
    mosiIn <= ~b[0];
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("FAIL watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rreg(CTRL, d);
    chk("ctrl reset", 8'h14, d);
    wreg(STAT, 8'hFF);
    wreg(8'hC6, 8'hFF);
    rreg(STAT, d);
    chk("status reset", 8'h00, d);
    rreg(8'hC6, d);
    chk("unmapped", 8'h00, d);
    // Collision write one cycle into a byte must not disturb it
    mxfer(3'h1, 8'hA5, 8'h3C, 1'b1);
    rreg(STAT, d);
    chk("status done col", 8'hC0, d);
    rreg(DATA, d);
    chk("rx byte", 8'h3C, d);
    rreg(STAT, d);
    chk("status cleared", 8'h00, d);
    // Second byte arrives while the done flag is still set
    mxfer(3'h2, 8'h11, 8'h22, 1'b0);
    mxfer(3'h2, 8'h33, 8'h44, 1'b0);
    rreg(STAT, d);
    rreg(DATA, d);
    chk("overrun keeps", 8'h22, d);
    // Select low in mid-byte: fault, shutdown, resend after clearing
    @(posedge clk);
    pSel <= 1'b0;
    wreg(CTRL, 8'h51);
    wreg(DATA, 8'hC3);
    repeat (12) @(posedge clk);
    ssN <= 1'b0;
    pSel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("err irq", 8'h01, {7'h00, rxErrIrq});
    ssN <= 1'b1;
    rreg(STAT, d);
    chk("fault flag", 8'h10, d);
    rreg(CTRL, d);
    chk("ctrl shut", 8'h01, d);
    wreg(CTRL, 8'h11);
    rreg(STAT, d);
    chk("fault clear", 8'h00, d);
    @(posedge clk);
    pSel <= 1'b0;
    wreg(CTRL, 8'h51);
    repeat (60) @(posedge clk);
    chk("resend", 8'hC3, pRx);
    rreg(STAT, d);
    rreg(DATA, d);
    pSel <= 1'b1;
    // Select disabled: low select is harmless
    wreg(CTRL, 8'h71);
    ssN <= 1'b0;
    repeat (4) @(posedge clk);
    chk("no err irq", 8'h00, {7'h00, rxErrIrq});
    ssN <= 1'b1;
    rreg(STAT, d);
    chk("no fault", 8'h00, d);
    // Reserved rates never clock; polarity 1 idles high
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 8'h00 : 8'h07;
      wreg(CTRL, 8'h00);
      wreg(CTRL, {d[2], 5'b10110, d[1:0]});
      wreg(DATA, 8'h5A);
      repeat (300) @(posedge clk);
      chk("sck idle", 8'h01, {7'h00, pinOut.sck});
      chk("no done", 8'h00, {7'h00, txIrq});
    end
    // Slave byte under the bench's clock, phase 0
    wreg(CTRL, 8'h00);
    wreg(CTRL, 8'h40);
    wreg(DATA, 8'h96);
    sbits(8'h5A, 8, d);
    chk("slave miso", 8'h96, d);
    chk("miso float", 8'h00, {7'h00, pinOut.misoOe});
    rreg(STAT, d);
    chk("slave done", 8'h80, d);
    rreg(DATA, d);
    chk("slave rx", 8'h5A, d);
    sbits(8'hF0, 3, d);
    rreg(STAT, d);
    chk("select error", 8'h20, d);
    wreg(CTRL, 8'h00);
    rreg(STAT, d);
    chk("sel err clear", 8'h00, d);
    summarize();
  end
endmodule
`default_nettype wire
